// file: hdl/query_pkg.sv
// constants shared by the query table responder and its lookup table
package query_pkg;

  // ****************************************
  // bus widths
  // ****************************************
  localparam int ADDR_W  = 24;
  localparam int DATA_W  = 16;
  localparam int BYTE_W  = 8;
  localparam int CMD_W   = 8;
  localparam int QOFFS_W = 8;

  // ****************************************
  // commands
  // ****************************************
  localparam logic [CMD_W-1:0] CMD_QUERY      = 8'h98;
  localparam logic [CMD_W-1:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [CMD_W-1:0] CMD_READ_STAT  = 8'h70;
  localparam logic [CMD_W-1:0] CMD_READ_IDENT = 8'h90;

  // ****************************************
  // query word offsets
  // ****************************************
  localparam logic [QOFFS_W-1:0] OFS_SIG0     = 8'h10;
  localparam logic [QOFFS_W-1:0] OFS_SIG1     = 8'h11;
  localparam logic [QOFFS_W-1:0] OFS_SIG2     = 8'h12;
  localparam logic [QOFFS_W-1:0] OFS_PRI_LO   = 8'h13;
  localparam logic [QOFFS_W-1:0] OFS_PRI_HI   = 8'h14;
  localparam logic [QOFFS_W-1:0] OFS_PTR_LO   = 8'h15;
  localparam logic [QOFFS_W-1:0] OFS_PTR_HI   = 8'h16;
  localparam logic [QOFFS_W-1:0] OFS_ALT_LO   = 8'h17;
  localparam logic [QOFFS_W-1:0] OFS_ALT_HI   = 8'h18;
  localparam logic [QOFFS_W-1:0] OFS_SEC_LO   = 8'h19;
  localparam logic [QOFFS_W-1:0] OFS_SEC_HI   = 8'h1A;
  localparam logic [QOFFS_W-1:0] OFS_RSV_LAST = 8'h0F;

  // ****************************************
  // table contents
  // ****************************************
  localparam logic [BYTE_W-1:0] VAL_SIG0   = 8'h51;
  localparam logic [BYTE_W-1:0] VAL_SIG1   = 8'h52;
  localparam logic [BYTE_W-1:0] VAL_SIG2   = 8'h59;
  localparam logic [BYTE_W-1:0] VAL_PTR_LO = 8'h0A;
  localparam logic [BYTE_W-1:0] VAL_PTR_HI = 8'h01;
  localparam logic [BYTE_W-1:0] VAL_ZERO   = 8'h00;
  localparam logic [BYTE_W-1:0] UPPER_LANE = 8'h00;
  // arbitrary value, names no real command set
  localparam logic [DATA_W-1:0] PRIMARY_CMDSET_CODE = 16'h0A5C;

  typedef enum logic [1:0] {
    mode_array,
    mode_query,
    mode_other
  } read_mode_t;

endpackage

// file: hdl/query_responder.sv
// read path of the flash that answers reads from the query database when asked
`timescale 1ns/1ps
module query_responder (
  // clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  // command write port
  input  wire logic                            cmd_wr,
  input  wire logic [query_pkg::CMD_W-1:0]     cmd_data,
  // read request
  input  wire logic                            rd_en,
  input  wire logic [query_pkg::ADDR_W-1:0]    rd_addr,
  // array data for the same read, from the array path
  input  wire logic [query_pkg::DATA_W-1:0]    array_data,
  // read answer
  output logic      [query_pkg::DATA_W-1:0]    rd_data,
  output logic                                 rd_valid,
  output logic                                 query_active
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    query_pkg::read_mode_t         mode;
    logic [query_pkg::DATA_W-1:0]  data;
    logic                          valid;
  } state_t;

  state_t                          cur;
  state_t                          next_cur;
  logic [query_pkg::BYTE_W-1:0]    table_byte;
  logic                            in_table;

  // offsets above the low byte of the word address are outside the table
  assign in_table = (rd_addr[query_pkg::ADDR_W-1:query_pkg::QOFFS_W] == '0);

  query_table u_table (
    .offset     (rd_addr[query_pkg::QOFFS_W-1:0]),
    .table_byte (table_byte)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_cur       = cur;
    next_cur.valid = 1'b0;
    // a read in the same cycle as a command still sees the old mode
    if (rd_en) begin
      next_cur.valid = 1'b1;
      if (cur.mode == query_pkg::mode_query) begin
        if (in_table) begin
          next_cur.data = {query_pkg::UPPER_LANE, table_byte};
        end else begin
          next_cur.data = '0;
        end
      end else begin
        // status and identifier reads belong to other blocks; pass array data here
        next_cur.data = array_data;
      end
    end
    if (cmd_wr) begin
      unique case (cmd_data)
        query_pkg::CMD_QUERY:      next_cur.mode = query_pkg::mode_query;
        query_pkg::CMD_READ_ARRAY: next_cur.mode = query_pkg::mode_array;
        query_pkg::CMD_READ_STAT,
        query_pkg::CMD_READ_IDENT: next_cur.mode = query_pkg::mode_other;
        // program and erase setup codes leave the read mode alone
        default:                   next_cur.mode = cur.mode;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur.mode  <= query_pkg::mode_array;
      cur.data  <= '0;
      cur.valid <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign rd_data      = cur.data;
  assign rd_valid     = cur.valid;
  assign query_active = (cur.mode == query_pkg::mode_query);

  // ****************************************
  // checks
  // ****************************************
  property p_enter_query;
    @(posedge core_clk) disable iff (rst)
      cmd_wr && cmd_data == query_pkg::CMD_QUERY |=> query_active;
  endproperty
  a_enter_query: assert property (p_enter_query)
    else $error("query command did not enter query mode");

  property p_upper_zero;
    @(posedge core_clk) disable iff (rst)
      rd_en && query_active |=> rd_valid && rd_data[15:8] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper lane not zero in query mode");

  property p_sig_q;
    @(posedge core_clk) disable iff (rst)
      rd_en && query_active && rd_addr == 24'h000010 |=> rd_data == 16'h0051;
  endproperty
  a_sig_q: assert property (p_sig_q)
    else $error("word 0x10 is not Q");

  property p_sig_ry;
    @(posedge core_clk) disable iff (rst)
      rd_en && query_active && rd_addr == 24'h000011 ##1
      rd_en && query_active && rd_addr == 24'h000012
      |-> rd_data == 16'h0052 ##1 rd_data == 16'h0059;
  endproperty
  a_sig_ry: assert property (p_sig_ry)
    else $error("words 0x11 and 0x12 are not R and Y");

  property p_primary_code;
    @(posedge core_clk) disable iff (rst)
      rd_en && query_active && rd_addr == 24'h000014
      |=> rd_data == {8'h00, query_pkg::PRIMARY_CMDSET_CODE[15:8]};
  endproperty
  a_primary_code: assert property (p_primary_code)
    else $error("word 0x14 is not the high code byte");

  property p_pointer;
    @(posedge core_clk) disable iff (rst)
      rd_en && query_active && (rd_addr == 24'h000015 || rd_addr == 24'h000016)
      |=> rd_data == ($past(rd_addr[1]) ? 16'h0001 : 16'h000A);
  endproperty
  a_pointer: assert property (p_pointer)
    else $error("extended table pointer wrong");

  property p_alt_sec_zero;
    @(posedge core_clk) disable iff (rst)
      rd_en && query_active && rd_addr >= 24'h000017 && rd_addr <= 24'h00001A
      |=> rd_data == 16'h0000;
  endproperty
  a_alt_sec_zero: assert property (p_alt_sec_zero)
    else $error("alternate or secondary word not zero");

  property p_reserved_zero;
    @(posedge core_clk) disable iff (rst)
      rd_en && query_active && rd_addr <= 24'h00000F |=> rd_data == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved word not zero");

  property p_mode_holds;
    @(posedge core_clk) disable iff (rst)
      query_active && !(cmd_wr && (cmd_data == query_pkg::CMD_READ_ARRAY
        || cmd_data == query_pkg::CMD_READ_STAT || cmd_data == query_pkg::CMD_READ_IDENT))
      |=> query_active;
  endproperty
  a_mode_holds: assert property (p_mode_holds)
    else $error("query mode left without a read mode command");

  property p_array_pass;
    @(posedge core_clk) disable iff (rst)
      rd_en && !query_active |=> rd_valid && rd_data == $past(array_data);
  endproperty
  a_array_pass: assert property (p_array_pass)
    else $error("array read not passed through outside query mode");

endmodule

// file: hdl/query_table.sv
// lookup of one query database byte by word offset
`timescale 1ns/1ps
module query_table (
  // lookup
  input  wire logic [query_pkg::QOFFS_W-1:0] offset,
  output logic      [query_pkg::BYTE_W-1:0]  table_byte
);

  always_comb begin
    unique case (offset)
      query_pkg::OFS_SIG0:   table_byte = query_pkg::VAL_SIG0;
      query_pkg::OFS_SIG1:   table_byte = query_pkg::VAL_SIG1;
      query_pkg::OFS_SIG2:   table_byte = query_pkg::VAL_SIG2;
      query_pkg::OFS_PRI_LO: table_byte = query_pkg::PRIMARY_CMDSET_CODE[7:0];
      query_pkg::OFS_PRI_HI: table_byte = query_pkg::PRIMARY_CMDSET_CODE[15:8];
      query_pkg::OFS_PTR_LO: table_byte = query_pkg::VAL_PTR_LO;
      query_pkg::OFS_PTR_HI: table_byte = query_pkg::VAL_PTR_HI;
      // alternate code, secondary pointer and reserved space all read zero
      default:               table_byte = query_pkg::VAL_ZERO;
    endcase
  end

endmodule

// file: verif/host_model.sv
// host side model: issues mode commands and word reads on the read path
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic                         core_clk,
  // command and read request
  output logic                              cmd_wr,
  output logic [query_pkg::CMD_W-1:0]       cmd_data,
  output logic                              rd_en,
  output logic [query_pkg::ADDR_W-1:0]      rd_addr,
  output logic [query_pkg::DATA_W-1:0]      array_data,
  // read answer
  input  wire logic [query_pkg::DATA_W-1:0] rd_data,
  input  wire logic                         rd_valid
);
  initial begin
    cmd_wr = 1'b0;
    cmd_data = 8'h00;
    rd_en = 1'b0;
    rd_addr = 24'h000000;
    array_data = 16'h0000;
  end
  // one strobe per command; released lines show a changed value, not the old one
  task automatic send_cmd(input logic [7:0] code);
    @(posedge core_clk);
    cmd_wr   <= 1'b1;
    cmd_data <= code;
    @(posedge core_clk);
    cmd_wr   <= 1'b0;
    cmd_data <= ~code;
  endtask
  // one word read per table byte; array word depends on address so mode shows
  task automatic read_word(input logic [23:0] addr, output logic [15:0] data,
                           output logic valid);
    @(posedge core_clk);
    rd_en      <= 1'b1;
    rd_addr    <= addr;
    array_data <= {addr[7:0], ~addr[7:0]};
    @(posedge core_clk);
    rd_en      <= 1'b0;
    rd_addr    <= ~addr;
    array_data <= {~addr[7:0], addr[7:0]};
    #1;
    data  = rd_data;
    valid = rd_valid;
  endtask
  // two word reads on consecutive cycles, the second at the next address
  task automatic read_pair(input logic [23:0] addr, output logic [15:0] first,
                           output logic [15:0] second, output logic valid);
    @(posedge core_clk);
    rd_en      <= 1'b1;
    rd_addr    <= addr;
    array_data <= {addr[7:0], ~addr[7:0]};
    @(posedge core_clk);
    rd_addr    <= addr + 24'h000001;
    array_data <= {~addr[7:0], addr[7:0]};
    #1;
    first = rd_data;
    @(posedge core_clk);
    rd_en      <= 1'b0;
    rd_addr    <= ~addr;
    array_data <= 16'h0000;
    #1;
    second = rd_data;
    valid  = rd_valid;
  endtask
endmodule

// file: verif/testbench.sv
// self-checking bench for the query table responder
`timescale 1ns/1ps
module testbench;
  logic        core_clk;
  logic        rst;
  logic        cmd_wr;
  logic [7:0]  cmd_data;
  logic        rd_en;
  logic [23:0] rd_addr;
  logic [15:0] array_data;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        query_active;
  logic [15:0] got;
  logic [15:0] got2;
  logic        vld;
  int          err_total;
  int          checked;
  logic [7:0]  exp_tab [0:10];
  logic [7:0]  codes [0:5];
  logic        modes [0:5];

  query_responder uut (.core_clk(core_clk), .rst(rst), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .array_data(array_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .query_active(query_active));
  host_model host (.core_clk(core_clk), .cmd_wr(cmd_wr), .cmd_data(cmd_data), .rd_en(rd_en),
    .rd_addr(rd_addr), .array_data(array_data), .rd_data(rd_data), .rd_valid(rd_valid));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check_flag(input string what, input logic exp, input logic seen);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // reads one word and checks the answer pulse together with the data
  task automatic read_check(input logic [23:0] addr, input logic [15:0] exp);
    host.read_word(addr, got, vld);
    check_flag("rd_valid", 1'b1, vld);
    check_word("rd_data", exp, got);
  endtask

  initial begin
    // a hang must not stall the run
    repeat (3000) @(posedge core_clk);
    err_total++;
    $display("Error watchdog expected finish seen timeout");
    conclude();
  end

  initial begin
    err_total = 0;
    checked = 0;
    rst = 1'b1;
    exp_tab = '{8'h51, 8'h52, 8'h59, query_pkg::PRIMARY_CMDSET_CODE[7:0],
                query_pkg::PRIMARY_CMDSET_CODE[15:8], 8'h0A, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    codes = '{8'h00, 8'h70, 8'h98, 8'h90, 8'h98, 8'hFF};
    modes = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    check_flag("query_active", 1'b0, query_active);
    check_flag("rd_valid", 1'b0, rd_valid);
    check_word("rd_data", 16'h0000, rd_data);
    read_check(24'h000010, 16'h10EF);
    host.send_cmd(8'h98);
    #1;
    check_flag("query_active", 1'b1, query_active);
    for (int i = 0; i < 11; i++) begin
      read_check(24'h000010 + i, {8'h00, exp_tab[i]});
    end
    for (int a = 0; a < 16; a++) begin
      read_check(a, 16'h0000);
    end
    read_check(24'h00001B, 16'h0000);
    read_check(24'h000110, 16'h0000);
    // unknown code first: mode must stand until a read mode command
    for (int k = 0; k < 6; k++) begin
      host.send_cmd(codes[k]);
      #1;
      check_flag("query_active", modes[k], query_active);
      read_check(24'h000012, modes[k] ? 16'h0059 : 16'h12ED);
    end
    // back to back reads, then the answer pulse must drop
    host.send_cmd(8'h98);
    host.read_pair(24'h000011, got, got2, vld);
    check_word("rd_data", 16'h0052, got);
    check_word("rd_data", 16'h0059, got2);
    check_flag("rd_valid", 1'b1, vld);
    @(posedge core_clk);
    #1;
    check_flag("rd_valid", 1'b0, rd_valid);
    // reset in mid-run must drop query mode
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    check_flag("query_active", 1'b0, query_active);
    check_flag("rd_valid", 1'b0, rd_valid);
    check_word("rd_data", 16'h0000, rd_data);
    read_check(24'h000010, 16'h10EF);
    conclude();
  end
endmodule
